/* design/odcd_pkg.sv */
// Shared constants, opcode layout and decode helpers for the debug port ends.
package odcd_pkg;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam logic [7:0] ACK_CHAR = 8'h40;
  // Opcode layout: kind in [7:5], address width or pointer select in [3:2], data width in [1:0].
  localparam int KIND_MSB = 7;
  localparam int KIND_LSB = 5;
  localparam logic [2:0] KIND_DIRECT_LOAD = 3'h0;
  localparam logic [2:0] KIND_INDIRECT_LOAD = 3'h1;
  localparam logic [2:0] KIND_DIRECT_STORE = 3'h2;
  localparam logic [2:0] KIND_INDIRECT_STORE = 3'h3;
  localparam logic [2:0] KIND_CTRL_SPACE_LOAD = 3'h4;
  localparam logic [2:0] KIND_REPEAT = 3'h5;
  localparam logic [2:0] KIND_CTRL_SPACE_STORE = 3'h6;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] PTR_AT = 2'h0;
  localparam logic [1:0] PTR_AT_INC = 2'h1;
  localparam logic [1:0] PTR_REG = 2'h2;
  // Control space: 16 bytes, index 0 reads status, index 2 holds the turnaround idle count.
  localparam int CS_DEPTH = 16;
  localparam logic [3:0] CS_STATUS_IDX = 4'h0;
  localparam logic [3:0] CS_GUARD_IDX = 4'h2;
  localparam logic [7:0] GUARD_RESET = 8'h02;
  localparam int GUARD_FIELD_W = 3;
  // Timing: one link bit time expressed in core clock cycles.
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int GUARD_CNT_W = 12;
  localparam int BUF_DEPTH = 2;

  function automatic logic [2:0] op_kind(input logic [7:0] op);
    return op[KIND_MSB:KIND_LSB];
  endfunction : op_kind

  // Reserved width or pointer codes make an opcode invalid; so does any unknown kind.
  function automatic logic op_valid(input logic [7:0] op);
    logic [2:0] k;
    k = op[KIND_MSB:KIND_LSB];
    case (k)
      KIND_DIRECT_LOAD, KIND_DIRECT_STORE: return op[3:2] <= SIZE_WORD && op[1:0] <= SIZE_WORD;
      KIND_INDIRECT_LOAD, KIND_INDIRECT_STORE: return op[3:2] <= PTR_REG && op[1:0] <= SIZE_WORD;
      KIND_CTRL_SPACE_LOAD, KIND_CTRL_SPACE_STORE: return 1'b1;
      KIND_REPEAT: return op[1:0] == SIZE_BYTE;
      default: return 1'b0;
    endcase
  endfunction : op_valid
endpackage : odcd_pkg

/* design/odcd_link_if.sv */
// Byte-level half-duplex link between the debugger end and the device end.
`timescale 1ns/10ps
interface odcd_link_if;
  logic h2dValid;
  logic h2dReady;
  logic [7:0] h2dData;
  logic h2dBreak;
  logic d2hValid;
  logic d2hReady;
  logic [7:0] d2hData;

  modport dev (
    input h2dValid,
    output h2dReady,
    input h2dData,
    input h2dBreak,
    output d2hValid,
    input d2hReady,
    output d2hData
  );

  modport host (
    output h2dValid,
    input h2dReady,
    output h2dData,
    output h2dBreak,
    input d2hValid,
    output d2hReady,
    input d2hData
  );
endinterface : odcd_link_if

/* design/odcd_skid_buf.sv */
// Two-entry flip-flop buffer with valid and ready on both sides.
`timescale 1ns/10ps
module odcd_skid_buf #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  logic [W-1:0] mem_ff [odcd_pkg::BUF_DEPTH];
  logic wrPtr_ff;
  logic rdPtr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign inReady = count_ff != 2'(odcd_pkg::BUF_DEPTH);
  assign outValid = count_ff != 2'h0;
  assign outData = mem_ff[rdPtr_ff];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wrPtr_ff <= ~wrPtr_ff;
      end
      if (pop) begin
        rdPtr_ff <= ~rdPtr_ff;
      end
      count_ff <= count_ff + 2'(push) - 2'(pop);
    end
  end
endmodule : odcd_skid_buf

/* design/odcd_device.sv */
// Device end: instruction decoder of the single-wire debug port.
`timescale 1ns/10ps
module odcd_device (
  input wire logic core_clk,
  input wire logic rst,
  odcd_link_if.dev link,
  output logic busReq,
  output logic busWrite,
  output logic busWide,
  output logic [15:0] busAddr,
  output logic [15:0] busWdata,
  input wire logic [15:0] busRdata,
  input wire logic busAck
);
  typedef enum logic [2:0] {
    S_SYNC, S_OP, S_ADDR, S_DIN, S_ACC, S_GUARD, S_TX, S_END
  } odcd_dev_state_type;

  odcd_dev_state_type state_ff;
  odcd_dev_state_type startState;
  logic [2:0] kind_ff;
  logic [1:0] sel_ff;
  logic [1:0] aw_ff;
  logic [1:0] dw_ff;
  logic [3:0] csIdx_ff;
  logic [15:0] addr_ff;
  logic [15:0] data_ff;
  logic [15:0] ptr_ff;
  logic [1:0] cnt_ff;
  logic [7:0] rpt_ff;
  logic storeDataPhase_ff;
  logic txAck_ff;
  logic execDone_ff;
  logic [odcd_pkg::GUARD_CNT_W-1:0] guard_ff;
  logic [7:0] cs_ff [odcd_pkg::CS_DEPTH];
  logic rxTake;
  logic rxLast;
  logic txLast;
  logic needBus;
  logic ptrIsTarget;
  logic pushValid;
  logic pushReady;
  logic [7:0] pushData;
  logic [7:0] csRead;
  logic [odcd_pkg::GUARD_CNT_W-1:0] guardLoad;

  assign link.h2dReady = state_ff == S_SYNC || state_ff == S_OP || state_ff == S_ADDR ||
      state_ff == S_DIN;
  assign rxTake = link.h2dValid && link.h2dReady;
  assign rxLast = cnt_ff == (state_ff == S_ADDR ? aw_ff : dw_ff);
  assign txLast = txAck_ff || cnt_ff == dw_ff;
  assign ptrIsTarget = sel_ff == odcd_pkg::PTR_REG;
  assign needBus = kind_ff == odcd_pkg::KIND_DIRECT_LOAD || kind_ff == odcd_pkg::KIND_DIRECT_STORE
      || ((kind_ff == odcd_pkg::KIND_INDIRECT_LOAD || kind_ff == odcd_pkg::KIND_INDIRECT_STORE)
      && !ptrIsTarget);
  // The idle time is counted at the fixed link bit rate, so it scales with the field value.
  assign guardLoad = odcd_pkg::GUARD_CNT_W'(
      cs_ff[odcd_pkg::CS_GUARD_IDX][odcd_pkg::GUARD_FIELD_W-1:0] * odcd_pkg::BIT_CYCLES);
  assign csRead = csIdx_ff == odcd_pkg::CS_STATUS_IDX ? {7'h00, |rpt_ff} : cs_ff[csIdx_ff];

  // Bus access: the pointer feeds indirect accesses, the received address feeds direct ones.
  assign busReq = state_ff == S_ACC && needBus;
  assign busWrite = kind_ff == odcd_pkg::KIND_DIRECT_STORE ||
      kind_ff == odcd_pkg::KIND_INDIRECT_STORE;
  assign busWide = dw_ff == odcd_pkg::SIZE_WORD;
  assign busAddr = (kind_ff == odcd_pkg::KIND_DIRECT_LOAD ||
      kind_ff == odcd_pkg::KIND_DIRECT_STORE) ? addr_ff : ptr_ff;
  assign busWdata = data_ff;

  always_comb begin
    case (kind_ff)
      odcd_pkg::KIND_DIRECT_LOAD, odcd_pkg::KIND_DIRECT_STORE: startState = S_ADDR;
      odcd_pkg::KIND_INDIRECT_STORE: startState = ptrIsTarget ? S_ADDR : S_DIN;
      odcd_pkg::KIND_INDIRECT_LOAD, odcd_pkg::KIND_CTRL_SPACE_LOAD: startState = S_ACC;
      default: startState = S_DIN;
    endcase
  end

  assign pushValid = state_ff == S_TX;
  assign pushData = txAck_ff ? odcd_pkg::ACK_CHAR : data_ff[8*cnt_ff[0] +: 8];

  // A break also drops reply bytes still waiting, so nothing stale follows it.
  odcd_skid_buf #(.W(8)) txBuf (
    .core_clk(core_clk),
    .rst(rst || link.h2dBreak),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(link.d2hValid),
    .outReady(link.d2hReady),
    .outData(link.d2hData)
  );

  // Main sequencer; a break on the link aborts everything, repeats included.
  always_ff @(posedge core_clk) begin
    if (rst || link.h2dBreak) begin
      state_ff <= S_SYNC;
      cnt_ff <= 2'h0;
      storeDataPhase_ff <= 1'b0;
      txAck_ff <= 1'b0;
      guard_ff <= '0;
      execDone_ff <= 1'b0;
    end else begin
      case (state_ff)
        S_SYNC: begin
          if (rxTake && link.h2dData == odcd_pkg::SYNC_CHAR) begin
            state_ff <= S_OP;
          end
        end
        S_OP: begin
          if (rxTake) begin
            state_ff <= odcd_pkg::op_valid(link.h2dData) ? S_END : S_SYNC;
            cnt_ff <= 2'h0;
            storeDataPhase_ff <= 1'b0;
          end
        end
        S_ADDR: begin
          if (rxTake) begin
            cnt_ff <= cnt_ff + 2'h1;
            if (rxLast) begin
              cnt_ff <= 2'h0;
              state_ff <= kind_ff == odcd_pkg::KIND_DIRECT_LOAD ? S_ACC : S_GUARD;
              txAck_ff <= 1'b1;
              guard_ff <= guardLoad;
            end
          end
        end
        S_DIN: begin
          if (rxTake) begin
            cnt_ff <= cnt_ff + 2'h1;
            if (rxLast) begin
              cnt_ff <= 2'h0;
              if (kind_ff == odcd_pkg::KIND_REPEAT) begin
                state_ff <= S_SYNC;
              end else if (kind_ff == odcd_pkg::KIND_CTRL_SPACE_STORE) begin
                state_ff <= S_END;
                execDone_ff <= 1'b1;
              end else begin
                state_ff <= S_ACC;
              end
            end
          end
        end
        S_ACC: begin
          if (!needBus || busAck) begin
            state_ff <= S_GUARD;
            txAck_ff <= busWrite;
            guard_ff <= guardLoad;
          end
        end
        S_GUARD: begin
          if (guard_ff == '0) begin
            state_ff <= S_TX;
          end else begin
            guard_ff <= guard_ff - 1'b1;
          end
        end
        S_TX: begin
          if (pushReady) begin
            cnt_ff <= cnt_ff + 2'h1;
            if (txLast) begin
              cnt_ff <= 2'h0;
              txAck_ff <= 1'b0;
              if (kind_ff == odcd_pkg::KIND_DIRECT_STORE && !storeDataPhase_ff) begin
                storeDataPhase_ff <= 1'b1;
                state_ff <= S_DIN;
              end else begin
                state_ff <= S_END;
                execDone_ff <= 1'b1;
              end
            end
          end
        end
        S_END: begin
          // Passed after the opcode and after each execution; a pending repeat reopens operands.
          storeDataPhase_ff <= 1'b0;
          execDone_ff <= 1'b0;
          if (execDone_ff && rpt_ff == 8'h00) begin
            state_ff <= S_SYNC;
          end else begin
            state_ff <= startState;
          end
        end
        default: state_ff <= S_SYNC;
      endcase
    end
  end

  // Repeat bookkeeping: execDone_ff marks in S_END that an execution has finished.
  always_ff @(posedge core_clk) begin
    if (rst || link.h2dBreak) begin
      rpt_ff <= 8'h00;
    end else if (state_ff == S_DIN && rxTake && kind_ff == odcd_pkg::KIND_REPEAT) begin
      rpt_ff <= link.h2dData;
    end else if (state_ff == S_END && execDone_ff && rpt_ff != 8'h00) begin
      rpt_ff <= rpt_ff - 8'h01;
    end
  end

  // Decoded opcode fields; they stay put through repeats so operands alone can follow.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      kind_ff <= odcd_pkg::KIND_DIRECT_LOAD;
      sel_ff <= odcd_pkg::PTR_AT;
      aw_ff <= odcd_pkg::SIZE_BYTE;
      dw_ff <= odcd_pkg::SIZE_BYTE;
      csIdx_ff <= 4'h0;
    end else if (state_ff == S_OP && rxTake) begin
      kind_ff <= odcd_pkg::op_kind(link.h2dData);
      sel_ff <= link.h2dData[3:2];
      csIdx_ff <= link.h2dData[3:0];
      case (odcd_pkg::op_kind(link.h2dData))
        odcd_pkg::KIND_DIRECT_LOAD, odcd_pkg::KIND_DIRECT_STORE: begin
          aw_ff <= link.h2dData[3:2];
          dw_ff <= link.h2dData[1:0];
        end
        odcd_pkg::KIND_INDIRECT_LOAD, odcd_pkg::KIND_INDIRECT_STORE: begin
          aw_ff <= link.h2dData[1:0];
          dw_ff <= link.h2dData[1:0];
        end
        default: begin
          aw_ff <= odcd_pkg::SIZE_BYTE;
          dw_ff <= odcd_pkg::SIZE_BYTE;
        end
      endcase
    end
  end

  // Address, data and pointer registers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_ff <= 16'h0000;
      data_ff <= 16'h0000;
      ptr_ff <= 16'h0000;
    end else begin
      if (state_ff == S_ADDR && rxTake) begin
        addr_ff[8*cnt_ff[0] +: 8] <= link.h2dData;
        if (kind_ff == odcd_pkg::KIND_INDIRECT_STORE) begin
          ptr_ff[8*cnt_ff[0] +: 8] <= link.h2dData;
          if (cnt_ff == 2'h0) begin
            ptr_ff[15:8] <= 8'h00;
          end
        end
        if (cnt_ff == 2'h0) begin
          addr_ff[15:8] <= 8'h00;
        end
      end
      if (state_ff == S_DIN && rxTake) begin
        data_ff[8*cnt_ff[0] +: 8] <= link.h2dData;
        if (cnt_ff == 2'h0) begin
          data_ff[15:8] <= 8'h00;
        end
      end
      if (state_ff == S_ACC && !busWrite) begin
        if (kind_ff == odcd_pkg::KIND_CTRL_SPACE_LOAD) begin
          data_ff <= {8'h00, csRead};
        end else if (kind_ff == odcd_pkg::KIND_INDIRECT_LOAD && ptrIsTarget) begin
          data_ff <= ptr_ff;
        end else if (busAck) begin
          data_ff <= busRdata;
        end
      end
      if (state_ff == S_ACC && busAck && busWrite && sel_ff == odcd_pkg::PTR_AT_INC &&
          kind_ff == odcd_pkg::KIND_INDIRECT_STORE) begin
        ptr_ff <= ptr_ff + (busWide ? 16'h0002 : 16'h0001);
      end
      if (state_ff == S_ACC && busAck && !busWrite && sel_ff == odcd_pkg::PTR_AT_INC &&
          kind_ff == odcd_pkg::KIND_INDIRECT_LOAD) begin
        ptr_ff <= ptr_ff + (busWide ? 16'h0002 : 16'h0001);
      end
    end
  end

  // Control space storage; a break restores the turnaround idle count default.
  always_ff @(posedge core_clk) begin
    if (rst || link.h2dBreak) begin
      for (int i = 0; i < odcd_pkg::CS_DEPTH; i++) begin
        cs_ff[i] <= i == int'(odcd_pkg::CS_GUARD_IDX) ? odcd_pkg::GUARD_RESET : 8'h00;
      end
    end else if (state_ff == S_DIN && rxTake && kind_ff == odcd_pkg::KIND_CTRL_SPACE_STORE) begin
      cs_ff[csIdx_ff] <= link.h2dData;
    end
  end
endmodule : odcd_device

/* design/odcd_host.sv */
// Debugger end: turns user commands into sync, opcode and operand frames.
`timescale 1ns/10ps
module odcd_host (
  input wire logic core_clk,
  input wire logic rst,
  odcd_link_if.host link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] cmdOp,
  input wire logic cmdHeader,
  input wire logic [15:0] cmdAddr,
  input wire logic [15:0] cmdData,
  input wire logic cmdBreak,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic rspAck
);
  typedef enum logic [2:0] {
    H_IDLE, H_SYNC, H_OP, H_ADDR, H_DATA, H_WACK, H_RESP, H_DONE
  } odcd_host_state_type;

  odcd_host_state_type state_ff;
  odcd_host_state_type afterOp;
  logic [7:0] op_ff;
  logic [15:0] addr_ff;
  logic [15:0] data_ff;
  logic [1:0] cnt_ff;
  logic [1:0] aw;
  logic [1:0] dw;
  logic [2:0] kind;
  logic phase_ff;
  logic ack_ff;
  logic brk_ff;
  logic hdr_ff;
  logic txTake;
  logic rxTake;

  assign kind = odcd_pkg::op_kind(op_ff);
  assign aw = (kind == odcd_pkg::KIND_DIRECT_LOAD || kind == odcd_pkg::KIND_DIRECT_STORE) ?
      op_ff[3:2] : op_ff[1:0];
  assign dw = (kind == odcd_pkg::KIND_CTRL_SPACE_LOAD || kind == odcd_pkg::KIND_CTRL_SPACE_STORE ||
      kind == odcd_pkg::KIND_REPEAT) ? odcd_pkg::SIZE_BYTE : op_ff[1:0];

  always_comb begin
    case (kind)
      odcd_pkg::KIND_DIRECT_LOAD, odcd_pkg::KIND_DIRECT_STORE: afterOp = H_ADDR;
      odcd_pkg::KIND_INDIRECT_STORE: afterOp = op_ff[3:2] == odcd_pkg::PTR_REG ? H_ADDR : H_DATA;
      odcd_pkg::KIND_INDIRECT_LOAD, odcd_pkg::KIND_CTRL_SPACE_LOAD: afterOp = H_RESP;
      default: afterOp = H_DATA;
    endcase
  end

  assign cmdReady = state_ff == H_IDLE && !brk_ff;
  assign link.h2dValid = state_ff == H_SYNC || (state_ff == H_OP && hdr_ff) || state_ff == H_ADDR ||
      state_ff == H_DATA;
  assign link.h2dData = state_ff == H_SYNC ? odcd_pkg::SYNC_CHAR :
      state_ff == H_OP ? op_ff :
      state_ff == H_ADDR ? addr_ff[8*cnt_ff[0] +: 8] : data_ff[8*cnt_ff[0] +: 8];
  assign link.h2dBreak = brk_ff;
  assign link.d2hReady = state_ff == H_WACK || state_ff == H_RESP;
  assign txTake = link.h2dValid && link.h2dReady;
  assign rxTake = link.d2hValid && link.d2hReady;
  assign rspValid = state_ff == H_DONE;
  assign rspAck = ack_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      brk_ff <= 1'b0;
    end else begin
      brk_ff <= cmdBreak;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || brk_ff) begin
      state_ff <= H_IDLE;
      op_ff <= 8'h00;
      addr_ff <= 16'h0000;
      data_ff <= 16'h0000;
      rspData <= 16'h0000;
      cnt_ff <= 2'h0;
      phase_ff <= 1'b0;
      ack_ff <= 1'b0;
      hdr_ff <= 1'b1;
    end else begin
      case (state_ff)
        H_IDLE: begin
          if (cmdValid) begin
            op_ff <= cmdOp;
            addr_ff <= cmdAddr;
            data_ff <= cmdData;
            cnt_ff <= 2'h0;
            phase_ff <= 1'b0;
            ack_ff <= 1'b1;
            hdr_ff <= cmdHeader;
            // Reserved codes are never put on the link; the command ends with no acknowledge.
            if (!odcd_pkg::op_valid(cmdOp)) begin
              ack_ff <= 1'b0;
              state_ff <= H_DONE;
            end else begin
              state_ff <= cmdHeader ? H_SYNC : H_OP;
            end
          end
        end
        H_SYNC: begin
          if (txTake) begin
            state_ff <= H_OP;
          end
        end
        H_OP: begin
          // Later repeat iterations send operands only, with neither sync nor opcode.
          if (!hdr_ff || txTake) begin
            state_ff <= afterOp;
          end
        end
        H_ADDR: begin
          if (txTake) begin
            cnt_ff <= cnt_ff + 2'h1;
            if (cnt_ff == aw) begin
              cnt_ff <= 2'h0;
              state_ff <= kind == odcd_pkg::KIND_DIRECT_LOAD ? H_RESP : H_WACK;
            end
          end
        end
        H_DATA: begin
          if (txTake) begin
            cnt_ff <= cnt_ff + 2'h1;
            if (cnt_ff == dw) begin
              cnt_ff <= 2'h0;
              state_ff <= (kind == odcd_pkg::KIND_CTRL_SPACE_STORE ||
                  kind == odcd_pkg::KIND_REPEAT) ? H_DONE : H_WACK;
            end
          end
        end
        H_WACK: begin
          if (rxTake) begin
            ack_ff <= ack_ff && link.d2hData == odcd_pkg::ACK_CHAR;
            // The data frame of a direct store goes out only once the address is acknowledged.
            if (kind == odcd_pkg::KIND_DIRECT_STORE && !phase_ff) begin
              phase_ff <= 1'b1;
              state_ff <= H_DATA;
            end else begin
              state_ff <= H_DONE;
            end
          end
        end
        H_RESP: begin
          if (rxTake) begin
            rspData[8*cnt_ff[0] +: 8] <= link.d2hData;
            if (cnt_ff == 2'h0) begin
              rspData[15:8] <= 8'h00;
            end
            cnt_ff <= cnt_ff + 2'h1;
            if (cnt_ff == dw) begin
              cnt_ff <= 2'h0;
              state_ff <= H_DONE;
            end
          end
        end
        H_DONE: state_ff <= H_IDLE;
        default: state_ff <= H_IDLE;
      endcase
    end
  end
endmodule : odcd_host

/* dv/odcd_link_assertions.sv */
// Protocol checks on the byte link between the debugger end and the device end.
`timescale 1ns/10ps
module odcd_link_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic h2dValid,
  input wire logic h2dReady,
  input wire logic [7:0] h2dData,
  input wire logic h2dBreak,
  input wire logic d2hValid,
  input wire logic d2hReady,
  input wire logic [7:0] d2hData
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_h2d_valid_hold: assert property (h2dValid && !h2dReady |=> h2dValid)
    else $error("host dropped a byte before it was taken");
  chk_h2d_data_hold: assert property (h2dValid && !h2dReady |=> $stable(h2dData))
    else $error("host byte changed while waiting");
  chk_d2h_valid_hold: assert property (d2hValid && !d2hReady |=> d2hValid)
    else $error("device dropped a reply byte");
  chk_d2h_data_hold: assert property (d2hValid && !d2hReady |=> $stable(d2hData))
    else $error("device reply byte changed while waiting");
  chk_reset_sync_wait: assert property ($fell(rst) |-> h2dReady && !d2hValid)
    else $error("device not waiting for sync after reset");
  chk_break_quiet: assert property (h2dBreak |=> !d2hValid)
    else $error("device replies during break");
  chk_half_duplex: assert property (d2hValid |-> !(h2dValid && h2dReady))
    else $error("device takes a byte while replying");
  chk_reply_after_gap: assert property ($rose(d2hValid) |-> !$past(h2dValid && h2dReady))
    else $error("reply starts without a turnaround gap");
  cov_reply: cover property (d2hValid && d2hReady);
  cov_break: cover property ($rose(h2dBreak));
  cov_stall: cover property (h2dValid && !h2dReady);
endmodule : odcd_link_assertions

/* dv/tb_top.sv */
// Testbench joining both ends of the debug port with a small system bus memory.
`timescale 1ns/10ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0, cmdHeader = 1'b1, cmdBreak = 1'b0, busAck = 1'b0;
  logic [7:0] cmdOp = 8'h00;
  logic [15:0] cmdAddr = 16'h0000, cmdData = 16'h0000, busRdata, rd;
  logic cmdReady, rspValid, rspAck, busReq, busWrite, busWide, ak, expSync = 1'b0;
  logic [15:0] rspData, busAddr, busWdata;
  logic [15:0] mem [0:255];
  int err_total = 0, num_checks = 0, busCount = 0, cyc, nb;
  always #2 core_clk = ~core_clk;
  odcd_link_if lnk();
  odcd_host odcd_host_inst (.core_clk(core_clk), .rst(rst), .link(lnk), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdHeader(cmdHeader), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdBreak(cmdBreak), .rspValid(rspValid), .rspData(rspData),
    .rspAck(rspAck));
  odcd_device odcd_device_inst (.core_clk(core_clk), .rst(rst), .link(lnk), .busReq(busReq),
    .busWrite(busWrite), .busWide(busWide), .busAddr(busAddr), .busWdata(busWdata),
    .busRdata(busRdata), .busAck(busAck));
  odcd_link_assertions odcd_link_assertions_inst (.core_clk(core_clk), .rst(rst),
    .h2dValid(lnk.h2dValid), .h2dReady(lnk.h2dReady), .h2dData(lnk.h2dData),
    .h2dBreak(lnk.h2dBreak), .d2hValid(lnk.d2hValid), .d2hReady(lnk.d2hReady),
    .d2hData(lnk.d2hData));
  // Byte reads return zero above bit 7 so a wrong width shows in the reply.
  assign busRdata = busWide ? mem[busAddr[7:0]] : {8'h00, mem[busAddr[7:0]][7:0]};
  always @(posedge core_clk) begin
    busAck <= busReq && !busAck;
    if (busReq && busAck) begin
      busCount <= busCount + 1;
      if (busWrite)
        mem[busAddr[7:0]] <= busWide ? busWdata : {mem[busAddr[7:0]][15:8], busWdata[7:0]};
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(posedge core_clk) begin
    if (cmdValid && cmdReady)
      expSync <= cmdHeader;
    else if (expSync && lnk.h2dValid && lnk.h2dReady) begin
      check({8'h00, lnk.h2dData}, {8'h00, odcd_pkg::SYNC_CHAR});
      expSync <= 1'b0;
    end
  end
  task run(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
    cmdOp <= op;
    cmdAddr <= a;
    cmdData <= d;
    cmdValid <= 1'b1;
    cyc = 0;
    nb = busCount;
    do @(posedge core_clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    while (rspValid !== 1'b1 && cyc < 5000) begin
      @(posedge core_clk);
      cyc++;
    end
    if (rspValid !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t no response to command", $time);
    end
    rd = rspData;
    ak = rspAck;
    nb = busCount - nb;
  endtask : run
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    // A short guard keeps the run brief; one bit time is still measurable.
    run({odcd_pkg::KIND_CTRL_SPACE_STORE, 1'b0, odcd_pkg::CS_GUARD_IDX}, 16'h0000, 16'h0001);
    check(16'(nb), 16'h0000);
    run({odcd_pkg::KIND_CTRL_SPACE_LOAD, 1'b0, odcd_pkg::CS_GUARD_IDX}, 16'h0000, 16'h0000);
    check(rd, 16'h0001);
    check(16'(cyc >= odcd_pkg::BIT_CYCLES), 16'h0001);
    run({odcd_pkg::KIND_DIRECT_STORE, 5'h05}, 16'h0010, 16'hbeef);
    check({15'h0000, ak}, 16'h0001);
    check(mem[16], 16'hbeef);
    run({odcd_pkg::KIND_DIRECT_LOAD, 5'h05}, 16'h0010, 16'h0000);
    check(rd, 16'hbeef);
    run({odcd_pkg::KIND_DIRECT_LOAD, 5'h04}, 16'h0010, 16'h0000);
    check(rd, 16'h00ef);
    run({odcd_pkg::KIND_INDIRECT_STORE, 1'b0, odcd_pkg::PTR_REG, 2'h1}, 16'h0020, 16'h0000);
    check({15'h0000, ak}, 16'h0001);
    run({odcd_pkg::KIND_INDIRECT_STORE, 1'b0, odcd_pkg::PTR_AT_INC, 2'h1}, 16'h0000, 16'h1234);
    check({15'h0000, ak}, 16'h0001);
    run({odcd_pkg::KIND_INDIRECT_STORE, 1'b0, odcd_pkg::PTR_AT, 2'h0}, 16'h0000, 16'h0056);
    check(mem[32], 16'h1234);
    check(mem[34], 16'h0056);
    run({odcd_pkg::KIND_INDIRECT_LOAD, 1'b0, odcd_pkg::PTR_AT_INC, 2'h0}, 16'h0000, 16'h0000);
    check(rd, 16'h0056);
    run({odcd_pkg::KIND_INDIRECT_LOAD, 1'b0, odcd_pkg::PTR_REG, 2'h1}, 16'h0000, 16'h0000);
    check(rd, 16'h0023);
    run({odcd_pkg::KIND_INDIRECT_STORE, 1'b0, odcd_pkg::PTR_REG, 2'h0}, 16'h0030, 16'h0000);
    run({odcd_pkg::KIND_REPEAT, 5'h00}, 16'h0000, 16'h0001);
    run({odcd_pkg::KIND_INDIRECT_STORE, 1'b0, odcd_pkg::PTR_AT_INC, 2'h0}, 16'h0000, 16'h0011);
    // The second pass of a repeat carries its data byte only.
    cmdHeader <= 1'b0;
    run({odcd_pkg::KIND_INDIRECT_STORE, 1'b0, odcd_pkg::PTR_AT_INC, 2'h0}, 16'h0000, 16'h0022);
    cmdHeader <= 1'b1;
    check({15'h0000, ak}, 16'h0001);
    check(mem[48], 16'h0011);
    check(mem[49], 16'h0022);
    run({odcd_pkg::KIND_CTRL_SPACE_LOAD, 1'b0, odcd_pkg::CS_STATUS_IDX}, 16'h0000, 16'h0000);
    check(rd, 16'h0000);
    run({odcd_pkg::KIND_DIRECT_LOAD, 5'h06}, 16'h0010, 16'h0000);
    check({15'h0000, ak}, 16'h0000);
    check(16'(nb), 16'h0000);
    cmdBreak <= 1'b1;
    repeat (4) @(posedge core_clk);
    cmdBreak <= 1'b0;
    run({odcd_pkg::KIND_CTRL_SPACE_LOAD, 1'b0, odcd_pkg::CS_GUARD_IDX}, 16'h0000, 16'h0000);
    check(rd, {8'h00, odcd_pkg::GUARD_RESET});
    give_verdict();
  end
endmodule : tb_top
